// ### include/fpc_regs.svh
// Register indices, field positions, configuration offsets and timing counts
`ifndef FPC_REGS_SVH
`define FPC_REGS_SVH

// Register indices; the byte address on the bus is four times the index
`define FPC_IDX_STATUS 10'h0F8
`define FPC_IDX_PROTECT 10'h0F9
`define FPC_IDX_COMMAND 10'h0FA
`define FPC_COMMAND_RESET 5'h00

// Status register write fields
`define FPC_FSR_DBG 7
`define FPC_FSR_WEN 5
`define FPC_FSR_CFGSEL 3

// Configuration page byte offsets, loaded in this order at start-up
`define FPC_CFG_BASE 14'h0020
`define FPC_CFG_UNPROTECTED_PAGE_COUNT 5'h00
`define FPC_CFG_DATA_AREA_ON 5'h01
`define FPC_CFG_RDCFG 5'h02
`define FPC_CFG_RDMAIN 5'h03
`define FPC_CFG_DBG 5'h04
`define FPC_CFG_LAST 5'h04
`define FPC_ERASED 8'hFF

// Top-of-main-block parity window
`define FPC_PARITY_BYTES 16'h0010
`define FPC_PARITY_LAST 5'h0F

// Geometry
`define FPC_PAGES_MAX 8'h20
`define FPC_DATA_PAGES 2

// Unlock keys and window
`define FPC_UNLOCK_KEY1 8'hAA
`define FPC_UNLOCK_KEY2 8'h55
`define FPC_UNLOCK_LOAD 7'h7F

// Processor write stall, in clock cycles
`define FPC_CPU_WR_STALL 10'h2E4

`define FPC_BLOCKED_DATA 8'h00
`define FPC_RESP_OKAY 2'h0
`define FPC_RESP_SLVERR 2'h2

`endif

// ### include/fpc_pkg.sv
// Types shared by the flash protection controller files
package fpc_pkg;
  localparam int FPC_ADDR_W = 14;

  typedef enum logic [1:0] {
    FPC_OP_READ = 2'h0,
    FPC_OP_WRITE = 2'h1,
    FPC_OP_ERASE = 2'h2
  } fpc_op_t;

  typedef struct packed {
    fpc_op_t op;
    logic cfg;
    logic [FPC_ADDR_W-1:0] addr;
    logic [7:0] wdata;
  } fpc_req_t;

  typedef struct packed {
    logic done;
    logic [7:0] rdata;
  } fpc_rsp_t;

  typedef enum logic [1:0] {
    FPC_ST_BOOT_CFG = 2'h0,
    FPC_ST_BOOT_PAR = 2'h1,
    FPC_ST_IDLE = 2'h3,
    FPC_ST_BUSY = 2'h2
  } fpc_state_t;
endpackage

// ### rtl/fpc_axil.sv
// AXI4-Lite slave front end for the flash protection registers
`timescale 1ns/100ps
`default_nettype none
`include "fpc_regs.svh"

module fpc_axil (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic wr_stb,
  output logic [9:0] wr_idx,
  output logic [7:0] wr_data,
  input wire logic wr_ok,
  output logic [9:0] rd_idx,
  input wire logic [7:0] rd_data,
  input wire logic rd_ok
);
  logic aw_full;
  logic w_full;
  logic w_lane;
  logic rd_pend;
  logic wr_fire;

  // Address and data may arrive in either order; the write fires once both are held and no response is pending
  assign wr_fire = aw_full && w_full && !s_axi_bvalid;
  assign wr_stb = wr_fire && w_lane && ce;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      s_axi_awready <= 1'b0;
      wr_idx <= '0;
    end else if (ce) begin
      if (wr_fire) begin
        aw_full <= 1'b0;
        s_axi_awready <= 1'b1;
      end else if (s_axi_awvalid && s_axi_awready) begin
        aw_full <= 1'b1;
        wr_idx <= s_axi_awaddr[11:2];
        s_axi_awready <= 1'b0;
      end else if (!aw_full) begin
        s_axi_awready <= 1'b1;
      end
    end
  end

  // Only byte lane 0 carries register data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full <= 1'b0;
      w_lane <= 1'b0;
      s_axi_wready <= 1'b0;
      wr_data <= '0;
    end else if (ce) begin
      if (wr_fire) begin
        w_full <= 1'b0;
        s_axi_wready <= 1'b1;
      end else if (s_axi_wvalid && s_axi_wready) begin
        w_full <= 1'b1;
        w_lane <= s_axi_wstrb[0];
        wr_data <= s_axi_wdata[7:0];
        s_axi_wready <= 1'b0;
      end else if (!w_full) begin
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `FPC_RESP_OKAY;
    end else if (ce) begin
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? `FPC_RESP_OKAY : `FPC_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Reads take one cycle to latch the index and one to sample the register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= `FPC_RESP_OKAY;
      rd_pend <= 1'b0;
      rd_idx <= '0;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        rd_idx <= s_axi_araddr[11:2];
        rd_pend <= 1'b1;
        s_axi_arready <= 1'b0;
      end else if (rd_pend) begin
        rd_pend <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h000000, rd_data};
        s_axi_rresp <= rd_ok ? `FPC_RESP_OKAY : `FPC_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end else if (!s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule // fpc_axil

`default_nettype wire

// ### rtl/fpc_top.sv
// Flash protection controller: start-up load, access rights, registers
//
// Function
// - Main block 32 pages of 512 bytes.
// - Start-up copies configuration bytes into registers.
// - Byte 0x20 gives unprotected count, 0xFF all.
// - Byte 0x21 not 0xFF enables data area.
// - Bytes 0x22, 0x23 set readback blocks.
// - Byte 0x24 enables debug unless main blocked.
// - Unprotected pages open to programmer; processor writes need status bit 5.
// - Protected pages: programmer full, processor read-only.
// - Two top data pages open to both.
// - Configuration page programmable only by programmer.
// - Status bit 7 holds writable debug enable.
// - Status bit 6 shows boot source.
// - Status bit 5 unlocks processor write/erase.
// - Status bit 4 reads 1 while busy.
// - Status bit 3 selects configuration page.
// - Status bits 2,1 readback flags, 0 zero.
// - Protect register: data enable, unprotected count.
// - Command register: erase page or unlock key.
// - Brown-out aborts write, requests chip reset.
// - Keys 0xAA, 0x55 open timed unlock window.
// - Boot source from parity of top 16 bytes when data area on.
// - Processor byte write stalls 740 cycles.
`timescale 1ns/100ps
`default_nettype none
`include "fpc_regs.svh"

module fpc_top #(
  parameter int PAGES = 32,
  parameter int PAGE_BYTES = 512
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic cpu_valid,
  input wire fpc_pkg::fpc_req_t cpu_req,
  output fpc_pkg::fpc_rsp_t cpu_rsp,
  output logic cpu_stall,
  input wire logic spi_valid,
  input wire fpc_pkg::fpc_req_t spi_req,
  output fpc_pkg::fpc_rsp_t spi_rsp,
  output logic fl_cmd_valid,
  output fpc_pkg::fpc_req_t fl_cmd,
  input wire logic fl_done,
  input wire logic [7:0] fl_rdata,
  output logic fl_abort,
  input wire logic brownout,
  output logic reset_request,
  output logic debug_enable_flag,
  output logic boot_from_protected
);
  localparam int AW = fpc_pkg::FPC_ADDR_W;
  localparam int PG_SH = $clog2(PAGE_BYTES);
  localparam int PW = AW - PG_SH;
  localparam int TOP_BASE = PAGES * PAGE_BYTES - int'(`FPC_PARITY_BYTES);

  // The page index is taken from the top address bits
  if (PAGES <= `FPC_DATA_PAGES || PAGES > int'(`FPC_PAGES_MAX) ||
      (1 << PG_SH) != PAGE_BYTES || PAGES * PAGE_BYTES > (1 << AW)) begin : g_bad_geometry
    $error("fpc_top: page count or page size not supported");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  fpc_pkg::fpc_state_t st;
  logic [4:0] boot_cnt;
  logic [AW-1:0] boot_addr;
  logic boot_cfg_ld;
  logic boot_par_ld;
  logic parity_acc;
  logic [6:0] unprotected_page_count;
  logic data_area_on;
  logic config_readback_block;
  logic main_readback_block;
  logic write_enable;
  logic config_page_select;
  logic [4:0] erase_page_index;
  logic erase_pend;
  logic [4:0] erase_page;
  logic erase_start;
  logic [1:0] unlock_stage;
  logic [6:0] unlock_cnt;
  logic unlock_open;
  logic own_cpu;
  logic own_spi;
  fpc_pkg::fpc_op_t cur_op;
  logic fl_seen;
  logic [7:0] rdata_hold;
  logic [9:0] stall_cnt;
  logic bo_s1;
  logic bo_s2;
  logic wr_stb;
  logic [9:0] wr_idx;
  logic [7:0] wr_data;
  logic wr_ok;
  logic [9:0] rd_idx;
  logic [7:0] rd_data;
  logic rd_ok;
  logic cmd_wr;
  logic status_wr;
  logic spi_blocked;
  logic cpu_ok;
  logic gap;
  logic abort_now;

  function automatic logic cpu_may_modify(input logic [PW-1:0] pg);
    logic in_range;
    logic open_pg;
    logic data_pg;
    in_range = int'(pg) < PAGES;
    open_pg = 7'(pg) < unprotected_page_count;
    data_pg = data_area_on && int'(pg) >= PAGES - `FPC_DATA_PAGES;
    cpu_may_modify = write_enable && !config_page_select && in_range && (open_pg || data_pg);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register bus

  fpc_axil u_axil (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_stb(wr_stb),
    .wr_idx(wr_idx),
    .wr_data(wr_data),
    .wr_ok(wr_ok),
    .rd_idx(rd_idx),
    .rd_data(rd_data),
    .rd_ok(rd_ok)
  );

  assign wr_ok = (wr_idx == `FPC_IDX_STATUS) || (wr_idx == `FPC_IDX_PROTECT) ||
                 (wr_idx == `FPC_IDX_COMMAND);
  assign status_wr = wr_stb && (wr_idx == `FPC_IDX_STATUS);
  assign cmd_wr = wr_stb && (wr_idx == `FPC_IDX_COMMAND);

  always_comb begin
    rd_ok = 1'b1;
    rd_data = 8'h00;
    if (rd_idx == `FPC_IDX_STATUS) begin
      rd_data = {debug_enable_flag, boot_from_protected, write_enable,
                 st != fpc_pkg::FPC_ST_IDLE, config_page_select,
                 main_readback_block, config_readback_block, 1'b0};
    end else if (rd_idx == `FPC_IDX_PROTECT) begin
      rd_data = {data_area_on, unprotected_page_count};
    end else if (rd_idx == `FPC_IDX_COMMAND) begin
      rd_data = {3'h0, erase_page_index};
    end else begin
      rd_ok = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Start-up configuration load

  assign boot_cfg_ld = (st == fpc_pkg::FPC_ST_BOOT_CFG) && fl_done;
  assign boot_par_ld = (st == fpc_pkg::FPC_ST_BOOT_PAR) && fl_done;

  always_comb begin
    if (st == fpc_pkg::FPC_ST_BOOT_CFG) begin
      boot_addr = `FPC_CFG_BASE + AW'(boot_cnt);
    end else begin
      boot_addr = AW'(TOP_BASE) + AW'(boot_cnt);
    end
  end

  // Erased bytes mean the unconfigured, fully open state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      unprotected_page_count <= 7'(PAGES);
      data_area_on <= 1'b0;
      config_readback_block <= 1'b0;
      main_readback_block <= 1'b0;
      parity_acc <= 1'b0;
      boot_from_protected <= 1'b0;
    end else if (ce) begin
      if (boot_cfg_ld) begin
        unique case (boot_cnt)
          `FPC_CFG_UNPROTECTED_PAGE_COUNT: begin
            unprotected_page_count <= (fl_rdata == `FPC_ERASED) ? 7'(PAGES) : fl_rdata[6:0];
          end
          `FPC_CFG_DATA_AREA_ON: data_area_on <= fl_rdata != `FPC_ERASED;
          `FPC_CFG_RDCFG: config_readback_block <= fl_rdata != `FPC_ERASED;
          `FPC_CFG_RDMAIN: main_readback_block <= fl_rdata != `FPC_ERASED;
          default: begin
          end
        endcase
      end
      if (boot_par_ld) begin
        parity_acc <= parity_acc ^ (^fl_rdata);
        if (boot_cnt == `FPC_PARITY_LAST) begin
          boot_from_protected <= data_area_on && (parity_acc ^ (^fl_rdata));
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status register and unlock window

  // The unlock counter runs at the system clock, so the window is 127 cycles
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      unlock_stage <= 2'h0;
      unlock_cnt <= 7'h00;
    end else if (ce) begin
      if (cmd_wr && wr_data == `FPC_UNLOCK_KEY1) begin
        unlock_stage <= 2'h1;
        unlock_cnt <= `FPC_UNLOCK_LOAD;
      end else if (cmd_wr && wr_data == `FPC_UNLOCK_KEY2 && unlock_stage == 2'h1 &&
                   unlock_cnt != 7'h00) begin
        unlock_stage <= 2'h2;
        unlock_cnt <= `FPC_UNLOCK_LOAD;
      end else if (cmd_wr) begin
        unlock_stage <= 2'h0;
        unlock_cnt <= 7'h00;
      end else if (unlock_cnt != 7'h00) begin
        unlock_cnt <= unlock_cnt - 7'h01;
      end else begin
        unlock_stage <= 2'h0;
      end
    end
  end

  assign unlock_open = (unlock_stage == 2'h2) && (unlock_cnt != 7'h00);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      debug_enable_flag <= 1'b0;
      write_enable <= 1'b0;
      config_page_select <= 1'b0;
    end else if (ce) begin
      if (boot_cfg_ld && boot_cnt == `FPC_CFG_DBG) begin
        debug_enable_flag <= (fl_rdata != `FPC_ERASED) && !main_readback_block;
      end else if (status_wr) begin
        debug_enable_flag <= wr_data[`FPC_FSR_DBG];
      end
      // Setting needs the open window; clearing is always allowed
      if (status_wr && (unlock_open || !wr_data[`FPC_FSR_WEN])) begin
        write_enable <= wr_data[`FPC_FSR_WEN];
      end
      if (status_wr) begin
        config_page_select <= wr_data[`FPC_FSR_CFGSEL];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command register and page erase request

  // A requester still holds valid in the cycle of its done, so nothing is taken then
  assign gap = cpu_rsp.done || spi_rsp.done;
  assign erase_start = (st == fpc_pkg::FPC_ST_IDLE) && !spi_valid && erase_pend && !gap;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      erase_page_index <= `FPC_COMMAND_RESET;
      erase_pend <= 1'b0;
      erase_page <= 5'h00;
    end else if (ce) begin
      if (cmd_wr) begin
        erase_page_index <= wr_data[4:0];
      end
      // A new request wins over the clear of the one being started
      if (cmd_wr && wr_data < `FPC_PAGES_MAX && cpu_may_modify(PW'(wr_data[4:0]))) begin
        erase_pend <= 1'b1;
        erase_page <= wr_data[4:0];
      end else if (erase_start) begin
        erase_pend <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Access sequencer

  assign spi_blocked = (spi_req.op == fpc_pkg::FPC_OP_READ) &&
                       (spi_req.cfg ? config_readback_block : main_readback_block);
  assign cpu_ok = (cpu_req.op == fpc_pkg::FPC_OP_READ) ||
                  ((cpu_req.op == fpc_pkg::FPC_OP_WRITE) && cpu_may_modify(cpu_req.addr[AW-1:PG_SH]));

  // Programmer first: it may be servicing a halted or blocked processor
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= fpc_pkg::FPC_ST_BOOT_CFG;
      boot_cnt <= 5'h00;
      fl_cmd_valid <= 1'b0;
      fl_cmd <= '0;
      own_cpu <= 1'b0;
      own_spi <= 1'b0;
      cur_op <= fpc_pkg::FPC_OP_READ;
      fl_seen <= 1'b0;
      rdata_hold <= 8'h00;
      stall_cnt <= 10'h000;
      cpu_rsp <= '0;
      spi_rsp <= '0;
      cpu_stall <= 1'b0;
    end else if (ce) begin
      cpu_rsp.done <= 1'b0;
      spi_rsp.done <= 1'b0;
      unique case (st)
        fpc_pkg::FPC_ST_BOOT_CFG, fpc_pkg::FPC_ST_BOOT_PAR: begin
          if (fl_done) begin
            fl_cmd_valid <= 1'b0;
            boot_cnt <= boot_cnt + 5'h01;
            if (st == fpc_pkg::FPC_ST_BOOT_CFG && boot_cnt == `FPC_CFG_LAST) begin
              st <= fpc_pkg::FPC_ST_BOOT_PAR;
              boot_cnt <= 5'h00;
            end else if (st == fpc_pkg::FPC_ST_BOOT_PAR && boot_cnt == `FPC_PARITY_LAST) begin
              st <= fpc_pkg::FPC_ST_IDLE;
            end
          end else if (!fl_cmd_valid) begin
            fl_cmd_valid <= 1'b1;
            fl_cmd <= '{op: fpc_pkg::FPC_OP_READ, cfg: st == fpc_pkg::FPC_ST_BOOT_CFG,
                        addr: boot_addr, wdata: 8'h00};
          end
        end
        fpc_pkg::FPC_ST_IDLE: begin
          fl_seen <= 1'b0;
          if (gap) begin
          end else if (spi_valid && spi_blocked) begin
            spi_rsp <= '{done: 1'b1, rdata: `FPC_BLOCKED_DATA};
          end else if (spi_valid) begin
            fl_cmd_valid <= 1'b1;
            fl_cmd <= spi_req;
            own_spi <= 1'b1;
            own_cpu <= 1'b0;
            cur_op <= spi_req.op;
            stall_cnt <= 10'h000;
            st <= fpc_pkg::FPC_ST_BUSY;
          end else if (erase_pend) begin
            fl_cmd_valid <= 1'b1;
            fl_cmd <= '{op: fpc_pkg::FPC_OP_ERASE, cfg: 1'b0,
                        addr: AW'(erase_page) << PG_SH, wdata: 8'h00};
            own_spi <= 1'b0;
            own_cpu <= 1'b0;
            cur_op <= fpc_pkg::FPC_OP_ERASE;
            stall_cnt <= 10'h000;
            cpu_stall <= 1'b1;
            st <= fpc_pkg::FPC_ST_BUSY;
          end else if (cpu_valid && !cpu_ok) begin
            cpu_rsp <= '{done: 1'b1, rdata: `FPC_BLOCKED_DATA};
          end else if (cpu_valid) begin
            fl_cmd_valid <= 1'b1;
            fl_cmd <= '{op: cpu_req.op, cfg: config_page_select,
                        addr: cpu_req.addr, wdata: cpu_req.wdata};
            own_spi <= 1'b0;
            own_cpu <= 1'b1;
            cur_op <= cpu_req.op;
            if (cpu_req.op == fpc_pkg::FPC_OP_WRITE) begin
              stall_cnt <= `FPC_CPU_WR_STALL - 10'h001;
              cpu_stall <= 1'b1;
            end else begin
              stall_cnt <= 10'h000;
            end
            st <= fpc_pkg::FPC_ST_BUSY;
          end
        end
        fpc_pkg::FPC_ST_BUSY: begin
          if (bo_s2 && cur_op != fpc_pkg::FPC_OP_READ) begin
            fl_cmd_valid <= 1'b0;
            cpu_stall <= 1'b0;
            st <= fpc_pkg::FPC_ST_IDLE;
          end else begin
            if (fl_done) begin
              fl_cmd_valid <= 1'b0;
              fl_seen <= 1'b1;
              rdata_hold <= fl_rdata;
            end
            if (stall_cnt != 10'h000) begin
              stall_cnt <= stall_cnt - 10'h001;
            end
            if ((fl_done || fl_seen) && stall_cnt == 10'h000) begin
              st <= fpc_pkg::FPC_ST_IDLE;
              cpu_stall <= 1'b0;
              if (own_spi) begin
                spi_rsp <= '{done: 1'b1, rdata: fl_seen ? rdata_hold : fl_rdata};
              end
              if (own_cpu) begin
                cpu_rsp <= '{done: 1'b1, rdata: fl_seen ? rdata_hold : fl_rdata};
              end
            end
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Brown-out

  // The detector is asynchronous to the system clock
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bo_s1 <= 1'b0;
      bo_s2 <= 1'b0;
    end else if (ce) begin
      bo_s1 <= brownout;
      bo_s2 <= bo_s1;
    end
  end

  assign abort_now = bo_s2 && st == fpc_pkg::FPC_ST_BUSY && cur_op != fpc_pkg::FPC_OP_READ;

  // Reset request stays until the chip reset clears it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fl_abort <= 1'b0;
      reset_request <= 1'b0;
    end else if (ce) begin
      fl_abort <= abort_now;
      if (abort_now) begin
        reset_request <= 1'b1;
      end
    end
  end
endmodule // fpc_top

`default_nettype wire

// ### tb/fpc_top_properties.sv
// Concurrent checks on the flash protection controller ports
`timescale 1ns/100ps
`default_nettype none
module fpc_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire fpc_pkg::fpc_rsp_t cpu_rsp,
  input wire logic cpu_stall,
  input wire logic fl_cmd_valid,
  input wire fpc_pkg::fpc_req_t fl_cmd,
  input wire logic fl_done,
  input wire logic fl_abort,
  input wire logic reset_request
);
  // Counted, too long for a repetition
  logic [9:0] stall_cnt;
  always_ff @(posedge aclk) begin
    stall_cnt <= cpu_stall ? stall_cnt + 10'h001 : 10'h000;
  end
  ////////////////////////////////////////
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_boot_start: assert property ($rose(aresetn) |=>
    fl_cmd_valid && fl_cmd.cfg && fl_cmd.addr == 14'h0020) else $error("no boot read");
  chk_stall_len: assert property (cpu_rsp.done && $past(cpu_stall) |->
    stall_cnt >= 10'h2E3) else $error("stall too short");
  chk_rr_sticky: assert property (reset_request |=> reset_request)
    else $error("reset request dropped");
  chk_abort_stop: assert property (fl_abort |=> !fl_cmd_valid && reset_request)
    else $error("abort left command");
  chk_cmd_hold: assert property (fl_cmd_valid && !fl_done |=>
    fl_abort || (fl_cmd_valid && $stable(fl_cmd))) else $error("command changed");
  chk_rd_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  chk_r_hold: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer held");
  chk_done_pulse: assert property (cpu_rsp.done |=> !cpu_rsp.done)
    else $error("done too long");
  cover property (fl_abort);
  cover property ($fell(cpu_stall));
  cover property (s_axi_rvalid && s_axi_rready);
endmodule // fpc_props
bind fpc_top fpc_props u_props (.*);
`default_nettype wire

// ### tb/fpc_flash_model.sv
// Flash array model answering the controller's commands
`timescale 1ns/100ps
`default_nettype none
module fpc_flash_model (
  input wire logic aclk,
  input wire logic slow,
  input wire logic fl_cmd_valid,
  input wire fpc_pkg::fpc_req_t fl_cmd,
  output logic fl_done,
  output logic [7:0] fl_rdata
);
  logic [7:0] mm [16384];
  logic [7:0] cm [512];
  int cnt = 0;
  initial begin
    fl_done = 1'b0;
    fl_rdata = 8'h00;
    foreach (mm[i]) mm[i] = 8'hFF;
    foreach (cm[i]) cm[i] = 8'hFF;
    {cm[36], cm[35], cm[34], cm[33], cm[32]} = 40'h00FFFF0010;
    mm[16383] = 8'hFE; // Odd count of ones at the top
  end
  ////////////////////////////////////////
  always @(posedge aclk) begin
    fl_done <= 1'b0;
    fl_rdata <= ~fl_rdata; // Stale data keeps moving so nobody relies on it
    cnt = (fl_cmd_valid && !fl_done) ? cnt + 1 : 0;
    if (cnt > (slow ? 40 : 1)) begin
      cnt = 0;
      fl_done <= 1'b1;
      fl_rdata <= fl_cmd.cfg ? cm[fl_cmd.addr[8:0]] : mm[fl_cmd.addr];
      if (fl_cmd.op == fpc_pkg::FPC_OP_WRITE && !fl_cmd.cfg)
        mm[fl_cmd.addr] &= fl_cmd.wdata;
      if (fl_cmd.op == fpc_pkg::FPC_OP_ERASE)
        for (int i = 0; i < 512; i++) mm[{fl_cmd.addr[13:9], 9'(i)}] = 8'hFF;
    end
  end
endmodule // fpc_flash_model
`default_nettype wire

// ### tb/testbench.sv
// Self-checking bench for the flash protection controller
`timescale 1ns/100ps
`default_nettype none
module testbench;
  localparam int LIM = 2000;
  logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, slow = 1'b0, brownout = 1'b0;
  localparam fpc_pkg::fpc_op_t rd_op = fpc_pkg::FPC_OP_READ, wr_op = fpc_pkg::FPC_OP_WRITE;
  logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
  logic s_axi_arvalid = '0, s_axi_rready = '0, cpu_valid = '0, spi_valid = '0;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, cpu_stall;
  logic fl_cmd_valid, fl_done, fl_abort, reset_request, debug_enable_flag, boot_from_protected;
  logic [7:0] fl_rdata;
  fpc_pkg::fpc_req_t cpu_req = '0, spi_req = '0, fl_cmd;
  fpc_pkg::fpc_rsp_t cpu_rsp, spi_rsp;
  logic [9:0] exp_q [$];
  int error_cnt = 0, compares = 0;
  fpc_top DUT (.*);
  fpc_flash_model u_flash (.*);
  always #4 aclk = ~aclk;
  ////////////////////////////////////////
  task chk(input logic [9:0] seen, input logic [9:0] want);
    compares++;
    if (seen !== want) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task summarize;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task lim(input int n);
    if (n >= LIM) begin
      error_cnt++;
      summarize();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    int n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= 32'(d);
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < LIM);
    s_axi_bready <= 1'b0;
    lim(n);
  endtask
  task automatic rd(input logic [11:0] a, input logic [9:0] e);
    int n = 0;
    @(posedge aclk);
    exp_q.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < LIM);
    s_axi_rready <= 1'b0;
    lim(n);
  endtask
  task automatic rq(input logic s, input fpc_pkg::fpc_op_t op, input logic [13:0] a,
      input logic [7:0] d, input logic [9:0] e = '0);
    int n = 0;
    @(posedge aclk);
    if (op == rd_op) exp_q.push_back(e);
    {cpu_req, spi_req} <= {2{op, 1'b0, a, d}};
    spi_valid <= s;
    cpu_valid <= !s;
    do begin
      @(posedge aclk);
      n++;
    end while (!(s ? spi_rsp.done : cpu_rsp.done) && n < LIM);
    spi_valid <= 1'b0;
    cpu_valid <= 1'b0;
    lim(n);
  endtask
  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready)
      chk({s_axi_rresp, s_axi_rdata[7:0]}, exp_q.pop_front());
    if (((cpu_rsp.done && cpu_valid) || (spi_rsp.done && spi_valid)) && spi_req.op == rd_op)
      chk({2'h0, cpu_valid ? cpu_rsp.rdata : spi_rsp.rdata}, exp_q.pop_front());
  end
  ////////////////////////////////////////
  initial begin
    logic [7:0] d;
    logic [13:0] a;
    int n, k = 0;
    void'($urandom(62));
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    for (n = 0; k < 21 && n < LIM; n++) begin
      @(posedge aclk);
      k += fl_done;
    end
    lim(n);
    rd(12'h3E4, 10'h090);
    rd(12'h3E0, 10'h0C0);
    rd(12'h3E8, 10'h000);
    rd(12'h3EC, 10'h200);
    $display("start-up done");
    wr(12'h3E0, 8'hA0);
    rd(12'h3E0, 10'h0C0);
    wr(12'h3E8, 8'hAA);
    wr(12'h3E8, 8'h55);
    wr(12'h3E0, 8'h20);
    rd(12'h3E0, 10'h060);
    rd(12'h3E8, 10'h015);
    $display("unlock done");
    a = {5'h00, 9'($urandom)};
    d = 8'($urandom);
    rq(1'b0, wr_op, a, d);
    rq(1'b0, rd_op, a, 8'h00, {2'h0, d});
    rq(1'b0, wr_op, 14'h3C00, d);
    rq(1'b0, rd_op, 14'h3C00, 8'h00, {2'h0, d});
    rq(1'b0, wr_op, 14'h2800, 8'h00);
    rq(1'b0, rd_op, 14'h2800, 8'h00, 10'h0FF);
    rq(1'b1, wr_op, 14'h2800, 8'h5A);
    rq(1'b1, rd_op, 14'h2800, 8'h00, 10'h05A);
    wr(12'h3E8, 8'h00);
    rq(1'b0, rd_op, a, 8'h00, 10'h0FF);
    $display("access done");
    @(posedge aclk);
    spi_req <= '{wr_op, 1'b0, 14'h0100, 8'h00};
    spi_valid <= 1'b1;
    slow <= 1'b1;
    repeat (10) @(posedge aclk);
    brownout <= 1'b1;
    for (n = 0; !reset_request && n < LIM; n++) @(posedge aclk);
    spi_valid <= 1'b0;
    chk({9'h000, reset_request}, 10'h001);
    lim(n);
    $display("brown-out done");
    summarize();
  end
endmodule // testbench
`default_nettype wire
